// File: rtl/ieu_ctrl.sv
`timescale 1ns/1ns
// Purpose: external priority controller answering acknowledge and end cycles
// Assumes: same clock as the entry unit
// Notes: one service at a time, lowest line number wins
module ieu_ctrl #(
	parameter int N_LINES = 16
) (
	input  wire logic               ref_clk_i,
	input  wire logic               resetn_i,
	ieu_if.ctl                      bus,
	input  wire logic [N_LINES-1:0] req_i,
	input  wire logic [N_LINES-1:0] casc_i,
	input  wire logic [7:0]         casc_vec_i,
	output logic [N_LINES-1:0]      pend_o,
	output logic                    active_o
);
	import ieu_pkg::*;

	logic [3:0] cur_q;
	logic [3:0] win;

	// lowest pending line number
	function automatic logic [3:0] first_set(input logic [N_LINES-1:0] p);
		logic [3:0] r;
		r = 4'h0;
		for (int i = N_LINES - 1; i >= 0; i--)
			if (p[i])
				r = 4'(i);
		return r;
	endfunction

	// vector for a line: cascaded lines give line minus 16
	function automatic logic [7:0] line_vec(input logic [3:0] l, input logic c);
		return c ? {CASC_TOP, l} : {4'h0, l}; // [RQ16] [RQ17]
	endfunction

	assign win = first_set(pend_o); // [RQ14]

	// pending latch, acknowledge and end-of-interrupt answers
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pend_o    <= '0;
			active_o  <= 1'b0;
			cur_q     <= 4'h0;
			bus.int_n <= 1'b1;
			bus.rdy   <= 1'b0;
			bus.vec   <= 8'h00;
		end
		else
		begin
			bus.rdy   <= 1'b0;
			bus.int_n <= !((|pend_o) && !active_o);
			pend_o    <= pend_o | req_i;
			if (bus.cyc && !bus.rdy)
			begin
				bus.rdy <= 1'b1;
				case (bus.kind)
					CYC_ACK_M:
					begin
						if (bus.addr == ADDR_NMI_ACK)
							bus.vec <= 8'h00;
						else
						begin
							bus.vec  <= line_vec(win, casc_i[win]); // [RQ13]
							cur_q    <= win;
							active_o <= |pend_o;
							pend_o   <= (pend_o & ~(N_LINES'(1) << win)) | req_i;
						end
					end
					CYC_EOI_M:
					begin
						bus.vec  <= line_vec(cur_q, casc_i[cur_q]); // [RQ15]
						active_o <= 1'b0;
					end
					CYC_ACK_C, CYC_EOI_C:
						bus.vec <= casc_vec_i;
					default:
						bus.vec <= 8'h00;
				endcase
			end
		end
	end
endmodule // ieu_ctrl

// File: rtl/ieu_entry.sv
`timescale 1ns/1ns
// Purpose: interrupt and trap entry and return sequencer of the processor
// Assumes: memory port answers each request with one mem_ack_i pulse
// Notes: abort pin takes a low of two cycles or more on the reset/abort line; a one-cycle pulse is filtered out
module ieu_entry (
	input  wire logic                    ref_clk_i,
	input  wire logic                    resetn_i,
	ieu_if.dev                           bus,
	input  wire logic                    nmi_n_i,
	input  wire logic                    reset_abort_line_n_i,
	input  wire logic                    trap_req_i,
	input  wire logic [7:0]              trap_vec_i,
	input  wire logic                    trace_req_i,
	input  wire logic                    boundary_i,
	input  wire logic [31:0]             ret_addr_i,
	input  wire logic                    setup_write_op_i,
	input  wire logic                    setup_vectored_i,
	input  wire logic                    base_we_i,
	input  wire logic [ieu_pkg::AW-1:0]  base_i,
	input  wire logic                    ret_req_i,
	input  wire logic                    service_return_op_i,
	input  wire logic [15:0]             ret_param_i,
	input  wire logic                    mem_ack_i,
	input  wire logic [ieu_pkg::DW-1:0]  mem_rdata_i,
	output logic                         mem_req_o,
	output logic                         mem_we_o,
	output logic [ieu_pkg::AW-1:0]       mem_addr_o,
	output logic [ieu_pkg::DW-1:0]       mem_wdata_o,
	output logic                         busy_o,
	output logic                         done_o,
	output logic [7:0]                   vector_o,
	output logic [31:0]                  pc_o,
	output logic [15:0]                  processor_status_word_o,
	output logic [15:0]                  unit_descriptor_reg_o,
	output logic [31:0]                  static_base_reg_o,
	output logic [ieu_pkg::AW-1:0]       sp_o,
	output logic [ieu_pkg::AW-1:0]       user_sp_o
);
	import ieu_pkg::*;

	typedef enum logic [14:0] {
		S_IDLE  = 15'h0001, S_ACK   = 15'h0002, S_CRD   = 15'h0004,
		S_CACK  = 15'h0008, S_DESC  = 15'h0010, S_PPC   = 15'h0020,
		S_PPSW  = 15'h0040, S_MSB   = 15'h0080, S_MPB   = 15'h0100,
		S_REOI  = 15'h0200, S_RCRD  = 15'h0400, S_RCEOI = 15'h0800,
		S_RPSW  = 15'h1000, S_RPC   = 15'h2000, S_RSB   = 15'h4000
	} ieu_state_t;

	typedef enum logic [4:0] {
		SRC_TRAP = 5'h01, SRC_ABT = 5'h02, SRC_NMI = 5'h04,
		SRC_INT  = 5'h08, SRC_TRC = 5'h10
	} ieu_src_t;

	ieu_state_t       st_q;
	ieu_src_t         src_q;
	logic             nmi_s;
	logic             abt_s;
	logic             nmi_prev_q;
	logic             abt_prev_q;
	logic             nmi_pend_q;
	logic             abt_pend_q;
	logic             vectored_q;
	logic [AW-1:0]    base_q;
	logic [15:0]      tmp_psw_q;
	logic [31:0]      desc_q;
	logic [15:0]      par_q;
	logic             int_ok;
	logic             take;
	logic             take_abt;
	logic             take_nmi;

	// table address: base plus vector times four, signed or unsigned
	function automatic logic [AW-1:0] tbl_addr(input logic [AW-1:0] b,
		input logic [7:0] v, input logic sgn);
		logic [AW-1:0] off;
		off = {{(AW-10){sgn & v[7]}}, v, 2'b00};
		return b + off;
	endfunction

	// pin inputs cross into the clock domain
	ieu_sync #(.RST_VAL(1'b1)) u_nmi_sync (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.d_i       (nmi_n_i),
		.q_o       (nmi_s)
	);
	ieu_sync #(.RST_VAL(1'b1)) u_abt_sync (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.d_i       (reset_abort_line_n_i),
		.q_o       (abt_s)
	);

	// request selection by fixed priority
	assign int_ok   = !bus.int_n && processor_status_word_o[PSW_I];        // [RQ8] [RQ9]
	assign take     = (st_q == S_IDLE) && !ret_req_i && boundary_i &&
		(trap_req_i || abt_pend_q || nmi_pend_q || int_ok || trace_req_i); // [RQ1]
	assign take_abt = take && !trap_req_i && abt_pend_q;                   // [RQ19]
	assign take_nmi = take && !trap_req_i && !abt_pend_q && nmi_pend_q;    // [RQ19]

	// edge flags for the non-maskable and abort pins, set beats clear
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			nmi_prev_q <= 1'b1;
			abt_prev_q <= 1'b1;
			nmi_pend_q <= 1'b0;
			abt_pend_q <= 1'b0;
		end
		else
		begin
			nmi_prev_q <= nmi_s;
			abt_prev_q <= abt_s;
			nmi_pend_q <= (nmi_prev_q && !nmi_s) || (nmi_pend_q && !take_nmi); // [RQ18]
			abt_pend_q <= (abt_prev_q && !abt_s) || (abt_pend_q && !take_abt);
		end
	end

	// vectored mode written by the setup operation, table base by base_we_i
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			vectored_q <= 1'b0;
			base_q     <= BASE_RESET;
		end
		else
		begin
			if (setup_write_op_i)
				vectored_q <= setup_vectored_i; // [RQ11]
			if (base_we_i)
				base_q <= base_i;
		end
	end

	// entry and return sequencer
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_q                    <= S_IDLE;
			src_q                   <= SRC_TRAP;
			mem_req_o               <= 1'b0;
			mem_we_o                <= 1'b0;
			mem_addr_o              <= '0;
			mem_wdata_o             <= '0;
			bus.cyc                 <= 1'b0;
			bus.kind                <= CYC_ACK_M;
			bus.addr                <= '0;
			busy_o                  <= 1'b0;
			done_o                  <= 1'b0;
			vector_o                <= VEC_NONVEC;
			pc_o                    <= '0;
			processor_status_word_o <= PSW_RESET;
			unit_descriptor_reg_o   <= '0;
			static_base_reg_o       <= '0;
			sp_o                    <= SP_RESET;
			user_sp_o               <= USP_RESET;
			tmp_psw_q               <= PSW_RESET;
			desc_q                  <= '0;
			par_q                   <= '0;
		end
		else
		begin
			done_o <= 1'b0;
			case (st_q)
				S_IDLE:
				begin
					if (ret_req_i)
					begin
						busy_o <= 1'b1;
						par_q  <= service_return_op_i ? 16'h0000 : ret_param_i; // [RQ7]
						src_q  <= service_return_op_i ? SRC_INT : SRC_TRAP;
						if (service_return_op_i)
						begin
							bus.cyc  <= 1'b1; // [RQ15]
							bus.kind <= CYC_EOI_M;
							bus.addr <= ADDR_INT_ACK;
							st_q     <= S_REOI;
						end
						else
						begin
							mem_req_o  <= 1'b1;
							mem_we_o   <= 1'b0;
							mem_addr_o <= sp_o;
							st_q       <= S_RPSW;
						end
					end
					else if (take)
					begin
						busy_o    <= 1'b1;
						pc_o      <= ret_addr_i;
						tmp_psw_q <= processor_status_word_o;                      // [RQ3]
						processor_status_word_o <= processor_status_word_o & ~PSW_CLR &
							~((trap_req_i || trace_req_i && !int_ok && !abt_pend_q &&
							!nmi_pend_q) ? 16'h0000 : PSW_CLR_I);           // [RQ3] [RQ10]
						if (trap_req_i || (!abt_pend_q && !nmi_pend_q && !int_ok))
						begin
							src_q      <= trap_req_i ? SRC_TRAP : SRC_TRC;
							vector_o   <= trap_req_i ? trap_vec_i : VEC_TRACE;
							mem_req_o  <= 1'b1;
							mem_we_o   <= 1'b0;
							mem_addr_o <= tbl_addr(base_q, trap_req_i ? trap_vec_i :
								VEC_TRACE, 1'b0);
							st_q       <= S_DESC;
						end
						else if (abt_pend_q)
						begin
							src_q      <= SRC_ABT;
							vector_o   <= VEC_ABORT;
							mem_req_o  <= 1'b1;
							mem_we_o   <= 1'b0;
							mem_addr_o <= tbl_addr(base_q, VEC_ABORT, 1'b0);
							st_q       <= S_DESC;
						end
						else
						begin
							src_q    <= nmi_pend_q ? SRC_NMI : SRC_INT;
							bus.cyc  <= 1'b1;                                       // [RQ2]
							bus.kind <= CYC_ACK_M;
							bus.addr <= nmi_pend_q ? ADDR_NMI_ACK : ADDR_INT_ACK;   // [RQ18]
							st_q     <= S_ACK;
						end
					end
				end
				S_ACK:
				begin
					if (bus.rdy)
					begin
						bus.cyc <= 1'b0;
						mem_req_o <= 1'b1;
						mem_we_o  <= 1'b0;
						if (src_q == SRC_NMI || !vectored_q)
						begin
							vector_o   <= (src_q == SRC_NMI) ? VEC_NMI : VEC_NONVEC; // [RQ12]
							mem_addr_o <= tbl_addr(base_q, (src_q == SRC_NMI) ?
								VEC_NMI : VEC_NONVEC, 1'b0);                      // [RQ18]
							st_q       <= S_DESC;
						end
						else
						begin
							vector_o   <= bus.vec;                                    // [RQ13]
							mem_addr_o <= tbl_addr(base_q, bus.vec, 1'b1);            // [RQ20] [RQ22]
							st_q       <= bus.vec[7] ? S_CRD : S_DESC;                // [RQ17]
						end
					end
				end
				S_CRD, S_RCRD:
				begin
					if (mem_ack_i)
					begin
						mem_req_o <= 1'b0;
						bus.cyc   <= 1'b1;                                          // [RQ21]
						bus.kind  <= (st_q == S_CRD) ? CYC_ACK_C : CYC_EOI_C;
						bus.addr  <= mem_rdata_i[AW-1:0];
						st_q      <= (st_q == S_CRD) ? S_CACK : S_RCEOI;
					end
				end
				S_CACK:
				begin
					if (bus.rdy)
					begin
						bus.cyc    <= 1'b0;
						vector_o   <= bus.vec;
						mem_req_o  <= 1'b1;
						mem_addr_o <= tbl_addr(base_q, bus.vec, 1'b0);                // [RQ21]
						st_q       <= S_DESC;
					end
				end
				S_DESC:
				begin
					if (mem_ack_i)
					begin
						desc_q      <= mem_rdata_i;                                  // [RQ4]
						mem_we_o    <= 1'b1;
						mem_addr_o  <= sp_o - WORD_BYTES;
						mem_wdata_o <= pc_o;                                         // [RQ5]
						sp_o        <= sp_o - WORD_BYTES;
						st_q        <= S_PPC;
					end
				end
				S_PPC:
				begin
					if (mem_ack_i)
					begin
						mem_addr_o  <= sp_o - WORD_BYTES;
						mem_wdata_o <= {tmp_psw_q, unit_descriptor_reg_o};           // [RQ5]
						sp_o        <= sp_o - WORD_BYTES;
						st_q        <= S_PPSW;
					end
				end
				S_PPSW:
				begin
					if (mem_ack_i)
					begin
						mem_we_o              <= 1'b0;
						unit_descriptor_reg_o <= desc_q[15:0];                        // [RQ4]
						mem_addr_o            <= {{(AW-16){1'b0}}, desc_q[15:0]};
						st_q                  <= S_MSB;
					end
				end
				S_MSB, S_RSB:
				begin
					if (mem_ack_i)
					begin
						static_base_reg_o <= mem_rdata_i;
						if (st_q == S_MSB)
						begin
							mem_addr_o <= mem_addr_o + MODT_PB_OFF;
							st_q       <= S_MPB;
						end
						else
						begin
							mem_req_o <= 1'b0;
							user_sp_o <= user_sp_o + {{(AW-16){1'b0}}, par_q};    // [RQ6]
							busy_o    <= 1'b0;
							done_o    <= 1'b1;
							st_q      <= S_IDLE;
						end
					end
				end
				S_MPB:
				begin
					if (mem_ack_i)
					begin
						mem_req_o <= 1'b0;
						pc_o      <= mem_rdata_i + {16'h0000, desc_q[31:16]};        // [RQ4]
						busy_o    <= 1'b0;
						done_o    <= 1'b1;
						st_q      <= S_IDLE;
					end
				end
				S_REOI, S_RCEOI:
				begin
					if (bus.rdy)
					begin
						bus.cyc   <= 1'b0;
						mem_req_o <= 1'b1;
						mem_we_o  <= 1'b0;
						if (st_q == S_REOI && bus.vec[7])
						begin
							mem_addr_o <= tbl_addr(base_q, bus.vec, 1'b1);            // [RQ15] [RQ17]
							st_q       <= S_RCRD;
						end
						else
						begin
							mem_addr_o <= sp_o;
							st_q       <= S_RPSW;
						end
					end
				end
				S_RPSW:
				begin
					if (mem_ack_i)
					begin
						processor_status_word_o <= mem_rdata_i[31:16];               // [RQ6] [RQ10]
						unit_descriptor_reg_o   <= mem_rdata_i[15:0];
						mem_addr_o              <= sp_o + WORD_BYTES;
						sp_o                    <= sp_o + WORD_BYTES;
						st_q                    <= S_RPC;
					end
				end
				S_RPC:
				begin
					if (mem_ack_i)
					begin
						pc_o       <= mem_rdata_i;                                   // [RQ6]
						sp_o       <= sp_o + WORD_BYTES;
						mem_addr_o <= {{(AW-16){1'b0}}, unit_descriptor_reg_o};
						st_q       <= S_RSB;
					end
				end
				default:
				begin
					st_q      <= S_IDLE;
					mem_req_o <= 1'b0;
					bus.cyc   <= 1'b0;
					busy_o    <= 1'b0;
				end
			endcase
		end
	end
endmodule // ieu_entry

// File: rtl/ieu_if.sv
`timescale 1ns/1ns
// Purpose: bus between entry unit and external priority controller
// Assumes: both ends on ref_clk_i
// Notes: cyc holds until rdy pulses for one cycle
interface ieu_if (input logic clk);
	logic        int_n;   // maskable request, active low level
	logic        cyc;     // special bus cycle in progress
	logic [1:0]  kind;    // acknowledge / end-of-interrupt, master / cascaded
	logic [23:0] addr;    // cycle address
	logic [7:0]  vec;     // low-order data byte from controller
	logic        rdy;     // one-cycle answer strobe
	modport dev (input int_n, vec, rdy, output cyc, kind, addr);
	modport ctl (output int_n, vec, rdy, input cyc, kind, addr);
endinterface // ieu_if

// File: rtl/ieu_pkg.sv
// Purpose: shared constants for the interrupt entry unit and its priority controller
// Assumes: single clock, byte addresses on a 24-bit bus, 32-bit memory words
// Notes: status word layout and acknowledge addresses are held here only
// Notes on behaviour
// RQ1: sources are maskable, non-maskable, abort, internal traps.
// RQ2: adjust registers, acquire vector, then service call.
// RQ3: save status word, force supervisor, interrupt stack.
// RQ4: dispatch entry at base plus vector, call descriptor.
// RQ5: service call pushes module register and return address.
// RQ6: trap return restores state and drops parameter bytes.
// RQ7: maskable uses service return; others use trap return.
// RQ8: maskable line is level sensitive, may repeat.
// RQ9: maskable requests taken only with enable bit set.
// RQ10: enable cleared on entry, restored by either return. Code leaves it set on trap and trace entries.
// RQ11: setup bit selects non-vectored or vectored mode.
// RQ12: non-vectored still acknowledges, uses vector zero.
// RQ13: vectored acknowledge reads low data byte from controller.
// RQ14: controller prioritises up to sixteen request inputs.
// RQ15: service return runs end-of-interrupt, controller re-sends vector.
// RQ16: lone controller supplies vectors zero to 127 only.
// RQ17: negative vector means cascade, never a dispatch index.
// RQ18: non-maskable falling edge: fixed acknowledge address, vector one.
// RQ19: priority: traps, abort, non-maskable, maskable, trace.
// RQ20: cascade entry at base plus (line-16) times 4.
// RQ21: cascaded acknowledge at table address, vector unsigned byte.
// RQ22: acknowledged vector byte read as signed value.
package ieu_pkg;
	localparam int          AW          = 24;
	localparam int          DW          = 32;
	// bus cycle kinds towards the priority controller
	localparam logic [1:0]  CYC_ACK_M   = 2'h0;
	localparam logic [1:0]  CYC_ACK_C   = 2'h1;
	localparam logic [1:0]  CYC_EOI_M   = 2'h2;
	localparam logic [1:0]  CYC_EOI_C   = 2'h3;
	localparam logic [23:0] ADDR_INT_ACK = 24'hFFFE00;
	localparam logic [23:0] ADDR_NMI_ACK = 24'hFFFF00;
	localparam logic [7:0]  VEC_NONVEC  = 8'h00;
	localparam logic [7:0]  VEC_NMI     = 8'h01;
	localparam logic [7:0]  VEC_ABORT   = 8'h02;
	localparam logic [7:0]  VEC_TRACE   = 8'h09;
	localparam logic [3:0]  CASC_TOP    = 4'hF; // upper nibble of line minus 16
	// status word bit positions
	localparam int          PSW_T       = 1;
	localparam int          PSW_U       = 8;
	localparam int          PSW_S       = 9;
	localparam int          PSW_P       = 10;
	localparam int          PSW_I       = 11;
	localparam logic [15:0] PSW_RESET   = 16'h0000;
	localparam logic [15:0] PSW_CLR     = 16'h0702; // S, U, T, P
	localparam logic [15:0] PSW_CLR_I   = 16'h0800;
	// stack frame and table geometry in bytes
	localparam logic [23:0] WORD_BYTES  = 24'h000004;
	localparam logic [23:0] MODT_PB_OFF = 24'h000008;
	localparam logic [23:0] SP_RESET    = 24'h001000;
	localparam logic [23:0] USP_RESET   = 24'h002000;
	localparam logic [23:0] BASE_RESET  = 24'h000400;
endpackage

// File: rtl/ieu_sync.sv
`timescale 1ns/1ns
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: asynchronous pin input
// Notes: output moves only when stages two and three agree
module ieu_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic ref_clk_i,
	input  wire logic resetn_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// shift chain, first stage feeds second only
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			q_o  <= RST_VAL;
		end
		else
		begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				q_o <= s3_q;
		end
	end
endmodule // ieu_sync

// File: verification/cpu_interrupt_entry_unit_tb_top.sv
// Purpose: bench for entry unit facing its priority controller
// Assumes: memory answered by a small word array
// Notes: rows cover each request source and its return
`timescale 1ns/1ns
module cpu_interrupt_entry_unit_tb_top;
	import ieu_pkg::*;
	typedef struct packed {
		logic [2:0] src; // 0 trap 1 trace 2 nmi 3 abort 4 int
		logic [7:0] num; // trap vector or line
		logic [7:0] vec; // expected vector
	} ieu_row_t;
	logic        ref_clk_i = 1'b0, resetn_i = 1'b0, nmi_n_i = 1'b1;
	logic        reset_abort_line_n_i = 1'b1, trap_req_i = 1'b0, trace_req_i = 1'b0;
	logic        boundary_i = 1'b1, setup_write_op_i = 1'b0, setup_vectored_i = 1'b0;
	logic        base_we_i = 1'b0, ret_req_i = 1'b0, service_return_op_i = 1'b0;
	logic        mem_ack_i = 1'b0, mem_req_o, mem_we_o, busy_o, done_o, active_o;
	logic [7:0]  trap_vec_i = 8'h00, casc_vec_i = 8'hC8, vector_o;
	logic [15:0] ret_param_i = 16'h0008, req_i = 16'h0000, casc_i = 16'h0008, pend_o;
	logic [15:0] processor_status_word_o, unit_descriptor_reg_o;
	logic [23:0] base_i = BASE_RESET, mem_addr_o, sp_o, user_sp_o, usp;
	logic [31:0] ret_addr_i = 32'h0, mem_rdata_i = 32'h0, mem_wdata_o, pc_o, static_base_reg_o;
	logic [31:0] mem [0:1023];
	int          n_fail = 0, checks = 0, i;
	ieu_row_t    rows [7] = '{'{3'd4, 8'd2, 8'd2}, '{3'd4, 8'd15, 8'd15},
		'{3'd4, 8'd3, 8'd200}, '{3'd2, 8'd0, 8'd1}, '{3'd3, 8'd0, 8'd2},
		'{3'd0, 8'd127, 8'd127}, '{3'd1, 8'd0, 8'd9}};

	ieu_if bus_if (.clk(ref_clk_i));
	ieu_entry ieu_entry_inst (.ref_clk_i, .resetn_i, .bus(bus_if.dev), .nmi_n_i,
		.reset_abort_line_n_i, .trap_req_i, .trap_vec_i, .trace_req_i, .boundary_i,
		.ret_addr_i, .setup_write_op_i, .setup_vectored_i, .base_we_i, .base_i, .ret_req_i,
		.service_return_op_i, .ret_param_i, .mem_ack_i, .mem_rdata_i, .mem_req_o, .mem_we_o,
		.mem_addr_o, .mem_wdata_o, .busy_o, .done_o, .vector_o, .pc_o,
		.processor_status_word_o, .unit_descriptor_reg_o, .static_base_reg_o, .sp_o,
		.user_sp_o);
	ieu_ctrl #(.N_LINES(16)) ieu_ctrl_inst (.ref_clk_i, .resetn_i, .bus(bus_if.ctl),
		.req_i, .casc_i, .casc_vec_i, .pend_o, .active_o);
	ieu_props ieu_props_inst (.ref_clk_i, .resetn_i, .int_n(bus_if.int_n), .cyc(bus_if.cyc),
		.kind(bus_if.kind), .addr(bus_if.addr), .vec(bus_if.vec), .rdy(bus_if.rdy));

	// clock
	initial
	begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// word memory, answers one cycle after a request
	always @(posedge ref_clk_i)
	begin
		mem_ack_i <= 1'b0;
		if (mem_req_o && !mem_ack_i)
		begin
			mem_ack_i   <= 1'b1;
			mem_rdata_i <= mem[mem_addr_o[11:2]];
			if (mem_we_o)
				mem[mem_addr_o[11:2]] <= mem_wdata_o;
		end
	end

	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// verdict and stop
	task automatic end_sim();
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// raise one source (5 trap return, 6 service return, 7 none), wait for done
	task automatic fire(input logic [2:0] src, input logic [7:0] num);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		trap_req_i           <= (src == 3'd0);
		trap_vec_i           <= num;
		trace_req_i          <= (src == 3'd1);
		nmi_n_i              <= (src != 3'd2);
		reset_abort_line_n_i <= (src != 3'd3);
		req_i                <= (src == 3'd4) ? (16'h0001 << num[3:0]) : 16'h0000;
		ret_req_i            <= (src == 3'd5 || src == 3'd6);
		service_return_op_i  <= (src == 3'd6);
		ret_addr_i           <= 32'h00003000 + {24'h0, num};
		@(posedge ref_clk_i);
		req_i     <= 16'h0000;
		ret_req_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i); // pins pass the synchroniser
		trap_req_i           <= 1'b0;
		trace_req_i          <= 1'b0;
		nmi_n_i              <= 1'b1;
		reset_abort_line_n_i <= 1'b1;
		while (done_o !== 1'b1 && n < 300)
		begin
			@(posedge ref_clk_i);
			n++;
		end
		chk("done", done_o, 32'h1);
		chk("idle", busy_o, 32'h0);
	endtask

	// watchdog
	initial
	begin
		repeat (6000) @(posedge ref_clk_i);
		n_fail++;
		end_sim();
	end

	// main sequence
	initial
	begin
		for (i = 0; i < 1024; i++)
			mem[i] = (i >= 256 && i < 512) ? {i[15:0] - 16'h0100, 16'h0100} : 32'h0;
		mem[10'h000] = 32'h00000777;
		mem[10'h040] = 32'h00005B00;
		mem[10'h042] = 32'h00001000;
		mem[10'h0F3] = 32'h0000A000;
		repeat (12) @(posedge ref_clk_i);
		chk("reset psw", processor_status_word_o, 32'h0);
		chk("reset sp", sp_o, SP_RESET);
		chk("reset int_n", bus_if.int_n, 32'h1);
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		req_i <= 16'h0004;
		@(posedge ref_clk_i);
		req_i <= 16'h0000;
		repeat (20) @(posedge ref_clk_i);
		chk("masked", busy_o, 32'h0);
		chk("int_n low", bus_if.int_n, 32'h0);
		chk("pending", pend_o, 32'h4);
		fire(3'd0, 8'h05);
		chk("trap vector", vector_o, 32'h5);
		chk("pc", pc_o, 32'h00001005);
		chk("mod", unit_descriptor_reg_o, 32'h0100);
		chk("sb", static_base_reg_o, 32'h00005B00);
		chk("sp", sp_o, SP_RESET - 24'h8);
		chk("pushed pc", mem[10'h3FF], 32'h00003005);
		mem[10'h3FE] = 32'h08000000;
		fire(3'd5, 8'h00);
		chk("psw back", processor_status_word_o, 32'h0800);
		chk("sb back", static_base_reg_o, 32'h00000777);
		chk("user sp", user_sp_o, USP_RESET + 24'h8);
		fire(3'd7, 8'h00);
		chk("nonvectored", vector_o, VEC_NONVEC);
		chk("psw entry", processor_status_word_o, 32'h0);
		fire(3'd6, 8'h00);
		chk("psw svc ret", processor_status_word_o, 32'h0800);
		@(posedge ref_clk_i);
		setup_write_op_i <= 1'b1;
		setup_vectored_i <= 1'b1;
		ret_param_i      <= 16'h0004;
		@(posedge ref_clk_i);
		setup_write_op_i <= 1'b0;
		usp = USP_RESET + 24'h8;
		for (i = 0; i < 7; i++)
		begin
			fire(rows[i].src, rows[i].num);
			chk("vector", vector_o, rows[i].vec);
			chk("entry pc", pc_o, 32'h1000 + rows[i].vec);
			chk("psw", processor_status_word_o, (rows[i].src < 3'd2) ? 32'h0800 : 32'h0);
			chk("stacked psw", mem[10'h3FE], 32'h08000000);
			chk("active", active_o, (rows[i].src == 3'd4) ? 32'h1 : 32'h0);
			usp = usp + ((rows[i].src == 3'd4) ? 24'h0 : 24'h4);
			fire((rows[i].src == 3'd4) ? 3'd6 : 3'd5, 8'h00);
			chk("psw ret", processor_status_word_o, 32'h0800);
			chk("pc ret", pc_o, 32'h3000 + rows[i].num);
			chk("user sp ret", user_sp_o, usp);
			chk("active ret", active_o, 32'h0);
		end
		// no entry off a boundary; trap beats trace when both wait
		@(posedge ref_clk_i);
		boundary_i  <= 1'b0;
		trap_req_i  <= 1'b1;
		trace_req_i <= 1'b1;
		trap_vec_i  <= 8'h06;
		repeat (4) @(posedge ref_clk_i);
		chk("no boundary", busy_o, 32'h0);
		boundary_i <= 1'b1;
		@(posedge ref_clk_i);
		trap_req_i  <= 1'b0;
		trace_req_i <= 1'b0;
		fire(3'd7, 8'h00);
		chk("priority", vector_o, 32'h6);
		// second reset in mid-run
		resetn_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		chk("rerun psw", processor_status_word_o, 32'h0);
		chk("rerun sp", sp_o, SP_RESET);
		chk("rerun user sp", user_sp_o, USP_RESET);
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		chk("rerun vector", vector_o, VEC_NONVEC);
		chk("rerun busy", busy_o, 32'h0);
		end_sim();
	end
endmodule // cpu_interrupt_entry_unit_tb_top

// File: verification/ieu_props.sv
// Purpose: checks the bus between entry unit and priority controller
// Assumes: one clock, reset active low
// Notes: sees the interface signals only
`timescale 1ns/1ns
module ieu_props
	import ieu_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        int_n,
	input  wire logic        cyc,
	input  wire logic [1:0]  kind,
	input  wire logic [23:0] addr,
	input  wire logic [7:0]  vec,
	input  wire logic        rdy
);
	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);
	// answer comes one cycle after a cycle is seen
	property p_answer;
		cyc && !rdy |=> rdy;
	endproperty
	a_answer: assert property (p_answer) else $error("answer not one cycle later");
	// answer strobe lasts one cycle
	property p_pulse;
		rdy |=> !rdy;
	endproperty
	a_pulse: assert property (p_pulse) else $error("answer strobe too long");
	// cycle kind and address stand until answered
	property p_hold;
		cyc && !rdy |=> cyc && $stable(kind) && $stable(addr);
	endproperty
	a_hold: assert property (p_hold) else $error("cycle dropped or changed");
	// no answer outside a cycle
	property p_in_cyc;
		rdy |-> cyc;
	endproperty
	a_in_cyc: assert property (p_in_cyc) else $error("answer without cycle");
	// master acknowledge only at the two fixed addresses
	property p_ack_addr;
		cyc && kind == CYC_ACK_M |-> addr == ADDR_INT_ACK || addr == ADDR_NMI_ACK;
	endproperty
	a_ack_addr: assert property (p_ack_addr) else $error("bad acknowledge address");
	// cascaded acknowledge only after a negative master vector
	property p_casc_ack;
		cyc && kind == CYC_ACK_C && !rdy |-> vec[7] && addr != ADDR_INT_ACK;
	endproperty
	a_casc_ack: assert property (p_casc_ack) else $error("cascade without negative vector");
	// cascaded end cycle only after a negative master vector
	property p_casc_eoi;
		cyc && kind == CYC_EOI_C && !rdy |-> vec[7];
	endproperty
	a_casc_eoi: assert property (p_casc_eoi) else $error("cascaded end without cascade");
	// vector byte only moves with an answer
	property p_vec_hold;
		$changed(vec) |-> rdy;
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector moved without answer");
	c_int: cover property ($fell(int_n));
endmodule // ieu_props
